//--- ovc_detect_top.sv
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/10ps
module ovc_detect_top
	import ovc_pkg::*;
#(
	parameter int P_SHORT_STEP_TICKS = SHORT_STEP_TICKS,
	parameter int P_DOC_BASE_TICKS = DOC_BASE_TICKS,
	parameter int P_DOC_STEP_TICKS = DOC_STEP_TICKS,
	parameter int P_BOOST_TICKS = BOOST_TICKS,
	parameter int P_WAKE_CAL_TICKS = WAKE_CAL_TICKS,
	parameter int P_WAKE_PERIOD_TICKS = WAKE_PERIOD_TICKS
) (
	input wire logic CLOCK_I,
	input wire logic RST_I,
	input wire logic [ADDR_W-1:0] ADDR_I,
	input wire logic [DATA_W-1:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [DATA_W-1:0] RDATA_O,
	input wire logic SC1_CMP_I,
	input wire logic SC2_CMP_I,
	input wire logic DOC_CMP_I,
	input wire logic COC_CMP_I,
	input wire logic BOOST_CMP_I,
	input wire logic WAKE_CMP_I,
	output logic [2:0] SC1_THR_O,
	output logic [2:0] SC2_THR_O,
	output logic SC2_RANGE_O,
	output logic [3:0] DOC_THR_O,
	output logic DOC_RANGE_O,
	output logic [2:0] COC_THR_O,
	output logic COC_RANGE_O,
	output logic [6:0] WAKE_THR_O,
	output logic [1:0] WAKE_GAIN_O,
	output logic [6:0] BOOST_THR_O,
	output logic WAKE_CAL_O,
	output logic WAKE_INT_O,
	output logic CHG_FET_O,
	output logic DSG_FET_O
);

	localparam logic [CNT_W-1:0] SHORT_STEP = CNT_W'(P_SHORT_STEP_TICKS);
	localparam logic [CNT_W-1:0] DOC_BASE = CNT_W'(P_DOC_BASE_TICKS);
	localparam logic [CNT_W-1:0] DOC_STEP = CNT_W'(P_DOC_STEP_TICKS);
	localparam logic [CNT_W-1:0] BOOST_LIM = CNT_W'(P_BOOST_TICKS);
	localparam logic [CNT_W-1:0] WAKE_CAL_LAST = CNT_W'(P_WAKE_CAL_TICKS - 1);
	localparam logic [CNT_W-1:0] WAKE_PERIOD_LAST = CNT_W'(P_WAKE_PERIOD_TICKS - 1);

	logic [DATA_W-1:0] fet_control_reg;
	logic [DATA_W-1:0] sc1_reg_r;
	logic [DATA_W-1:0] sc2_reg_r;
	logic [DATA_W-1:0] doc_reg_r;
	logic [DATA_W-1:0] coc_reg_r;
	logic [DATA_W-1:0] wake_detect_control;
	logic [DATA_W-1:0] wake_detect_control2;
	logic [NUM_FLAGS-1:0] flag_r;
	logic [NUM_FLAGS-1:0] cmp_raw;
	logic [NUM_FLAGS-1:0] cmp_meta_r;
	logic [NUM_FLAGS-1:0] cmp_sync_r;
	logic [NUM_FLAGS-1:0] hit;
	logic [NUM_QUAL-1:0] qual_en;
	logic [CNT_W-1:0] qual_lim [NUM_QUAL];
	logic slow_detect_clock_tick;
	logic charge_fet_on;
	logic discharge_fet_on;
	logic short1_fet_off_enable;
	logic short2_fet_off_enable;
	logic dischg_oc_fet_off_enable;
	logic chg_oc_fet_off_enable;
	logic boost_charge_fet_on_enable;
	logic dsg_forced;
	logic chg_forced;
	logic chg_boosted;
	logic wake_armed;
	logic status_wr;
	ovc_wake_e wake_state_r;
	logic [CNT_W-1:0] wake_cnt_r;
	logic wake_seen_r;
	logic [3:0] sc1_time;
	logic [3:0] sc2_time;
	logic [3:0] doc_time;
	logic [3:0] coc_time;
	logic [2:0] sc2_thr_nxt;
	logic sc2_range_nxt;
	logic [3:0] doc_thr_nxt;
	logic doc_range_nxt;
	logic [2:0] coc_thr_nxt;
	logic coc_range_nxt;
	logic [6:0] wake_thr_nxt;
	logic [6:0] boost_thr_nxt;
	logic [1:0] gain_nxt;
	logic [DATA_W-1:0] rdata_nxt;

	// Comparator results come from the analog side, so each is synchronised
	assign cmp_raw = {WAKE_CMP_I, BOOST_CMP_I, COC_CMP_I, DOC_CMP_I, SC2_CMP_I, SC1_CMP_I};

	genvar gi;
	generate
		for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_sync
			always_ff @(posedge CLOCK_I) begin
				if (RST_I) begin
					cmp_meta_r[gi] <= 1'b0;
					cmp_sync_r[gi] <= 1'b0;
				end else begin
					cmp_meta_r[gi] <= cmp_raw[gi];
					cmp_sync_r[gi] <= cmp_meta_r[gi];
				end
			end
		end
	endgenerate

	ovc_prescale u_prescale (
		.clk_i(CLOCK_I),
		.rst_i(RST_I),
		.tick_o(slow_detect_clock_tick)
	);

	// Register writes
	assign status_wr = WR_I && ADDR_I == OFS_STATUS;

	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			fet_control_reg <= RST_REG;
			sc1_reg_r <= RST_REG;
			sc2_reg_r <= RST_REG;
			doc_reg_r <= RST_REG;
			coc_reg_r <= RST_REG;
			wake_detect_control <= RST_REG;
			wake_detect_control2 <= RST_REG;
		end else if (WR_I) begin
			unique case (ADDR_I)
				OFS_FET: fet_control_reg <= WDATA_I;
				OFS_SC1: sc1_reg_r <= WDATA_I;
				OFS_SC2: sc2_reg_r <= WDATA_I;
				OFS_DOC: doc_reg_r <= WDATA_I;
				OFS_COC: coc_reg_r <= WDATA_I;
				OFS_WAKE: wake_detect_control <= WDATA_I;
				OFS_WAKE2: wake_detect_control2 <= WDATA_I;
				default: begin
				end
			endcase
		end
	end

	assign charge_fet_on = fet_control_reg[CHG_ON_BIT];
	assign discharge_fet_on = fet_control_reg[DSG_ON_BIT];
	assign short1_fet_off_enable = sc1_reg_r[FET_EN_BIT];
	assign short2_fet_off_enable = sc2_reg_r[FET_EN_BIT];
	assign dischg_oc_fet_off_enable = doc_reg_r[FET_EN_BIT];
	assign chg_oc_fet_off_enable = coc_reg_r[FET_EN_BIT];
	assign boost_charge_fet_on_enable = wake_detect_control2[FET_EN_BIT];

	// Time codes pass straight through; the DOC clamp at SHORT_TIME_MAX never acts on a 4-bit code
	assign sc1_time = {1'b0, sc1_reg_r[TIME_LSB +: 3]};
	assign sc2_time = sc2_reg_r[TIME_LSB +: 4];
	assign coc_time = coc_reg_r[TIME_LSB +: 4];
	assign doc_time = doc_reg_r[TIME_LSB +: 4] > SHORT_TIME_MAX ? SHORT_TIME_MAX
		: doc_reg_r[TIME_LSB +: 4];

	assign qual_en[DET_SC1] = sc1_reg_r[DET_EN_BIT];
	assign qual_en[DET_SC2] = sc2_reg_r[DET_EN_BIT];
	assign qual_en[DET_DOC] = doc_reg_r[DET_EN_BIT];
	assign qual_en[DET_COC] = coc_reg_r[DET_EN_BIT];
	assign qual_en[DET_BOOST] = wake_detect_control2[DET_EN_BIT];

	assign qual_lim[DET_SC1] = CNT_W'(sc1_time * SHORT_STEP);
	assign qual_lim[DET_SC2] = CNT_W'(sc2_time * SHORT_STEP);
	assign qual_lim[DET_COC] = CNT_W'(coc_time * SHORT_STEP);
	assign qual_lim[DET_DOC] = CNT_W'(DOC_BASE + doc_time * DOC_STEP);
	assign qual_lim[DET_BOOST] = BOOST_LIM;

	generate
		for (gi = 0; gi < NUM_QUAL; gi++) begin : g_qual
			ovc_qualify u_qual (
				.clk_i(CLOCK_I),
				.rst_i(RST_I),
				.enable_i(qual_en[gi]),
				.cmp_i(cmp_sync_r[gi]),
				.tick_i(slow_detect_clock_tick),
				.limit_i(qual_lim[gi]),
				.hit_o(hit[gi])
			);
		end
	endgenerate

	// Threshold codes; a coarse code equal to the top of the fine range
	// is sent as the fine code, since the analog side trims only that range.
	always_comb begin
		sc2_range_nxt = sc2_reg_r[RANGE_BIT];
		sc2_thr_nxt = sc2_reg_r[2:0] > SC2_CODE_MAX ? SC2_CODE_MAX : sc2_reg_r[2:0];
		if (sc2_range_nxt && sc2_thr_nxt == 3'h0) begin
			sc2_range_nxt = 1'b0;
			sc2_thr_nxt = SC2_CODE_MAX;
		end
		coc_range_nxt = coc_reg_r[RANGE_BIT];
		coc_thr_nxt = coc_reg_r[2:0] > SC2_CODE_MAX ? SC2_CODE_MAX : coc_reg_r[2:0];
		if (coc_range_nxt && coc_thr_nxt == 3'h0) begin
			coc_range_nxt = 1'b0;
			coc_thr_nxt = SC2_CODE_MAX;
		end
		doc_range_nxt = doc_reg_r[RANGE_BIT];
		doc_thr_nxt = doc_reg_r[3:0] > DOC_CODE_MAX ? DOC_CODE_MAX : doc_reg_r[3:0];
		if (doc_range_nxt && doc_thr_nxt == 4'h0) begin
			doc_range_nxt = 1'b0;
			doc_thr_nxt = DOC_CODE_MAX;
		end
		wake_thr_nxt = wake_detect_control[6:0] > WAKE_CODE_MAX ? WAKE_CODE_MAX
			: wake_detect_control[6:0];
		boost_thr_nxt = wake_detect_control2[6:0] > WAKE_CODE_MAX ? WAKE_CODE_MAX
			: wake_detect_control2[6:0];
		gain_nxt = wake_detect_control[GAIN_LSB +: 2];
		if (gain_nxt != GAIN_X5 && gain_nxt != GAIN_X2) begin
			gain_nxt = GAIN_X10;
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			SC1_THR_O <= 3'h0;
			SC2_THR_O <= 3'h0;
			SC2_RANGE_O <= 1'b0;
			DOC_THR_O <= 4'h0;
			DOC_RANGE_O <= 1'b0;
			COC_THR_O <= 3'h0;
			COC_RANGE_O <= 1'b0;
			WAKE_THR_O <= 7'h00;
			BOOST_THR_O <= 7'h00;
			WAKE_GAIN_O <= GAIN_X10;
		end else begin
			SC1_THR_O <= sc1_reg_r[2:0];
			SC2_THR_O <= sc2_thr_nxt;
			SC2_RANGE_O <= sc2_range_nxt;
			DOC_THR_O <= doc_thr_nxt;
			DOC_RANGE_O <= doc_range_nxt;
			COC_THR_O <= coc_thr_nxt;
			COC_RANGE_O <= coc_range_nxt;
			WAKE_THR_O <= wake_thr_nxt;
			BOOST_THR_O <= boost_thr_nxt;
			WAKE_GAIN_O <= gain_nxt;
		end
	end

	// Wakeup detection only runs in power-down with integration stopped
	assign wake_armed = wake_detect_control[DET_EN_BIT] && fet_control_reg[PWRDN_BIT]
		&& !fet_control_reg[INTEG_EN_BIT];

	always_ff @(posedge CLOCK_I) begin
		if (RST_I || !wake_armed) begin
			wake_state_r <= WAKE_IDLE;
			wake_cnt_r <= '0;
			wake_seen_r <= 1'b0;
		end else begin
			unique case (wake_state_r)
				WAKE_IDLE: begin
					wake_state_r <= WAKE_CAL;
					wake_cnt_r <= '0;
					wake_seen_r <= 1'b0;
				end
				WAKE_CAL: begin
					if (slow_detect_clock_tick) begin
						wake_cnt_r <= wake_cnt_r + 1'b1;
						if (wake_cnt_r == WAKE_CAL_LAST) begin
							wake_state_r <= WAKE_MEAS;
						end
					end
				end
				WAKE_MEAS: begin
					wake_seen_r <= wake_seen_r || cmp_sync_r[DET_WAKE];
					if (slow_detect_clock_tick) begin
						wake_cnt_r <= wake_cnt_r + 1'b1;
						if (wake_cnt_r == WAKE_PERIOD_LAST) begin
							wake_state_r <= WAKE_CAL;
							wake_cnt_r <= '0;
							wake_seen_r <= 1'b0;
						end
					end
				end
			endcase
		end
	end

	assign hit[DET_WAKE] = wake_armed && wake_state_r == WAKE_MEAS && slow_detect_clock_tick
		&& wake_cnt_r == WAKE_PERIOD_LAST && (wake_seen_r || cmp_sync_r[DET_WAKE]);

	// Sticky flags: a new event wins over a clear in the same cycle
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			flag_r <= '0;
		end else if (status_wr) begin
			flag_r <= (flag_r & ~WDATA_I[NUM_FLAGS-1:0]) | hit;
		end else begin
			flag_r <= flag_r | hit;
		end
	end

	// Forced states hold until software clears the causing flag or that detector's FET-off enable bit
	assign dsg_forced = (flag_r[DET_SC1] && short1_fet_off_enable)
		|| (flag_r[DET_SC2] && short2_fet_off_enable)
		|| (flag_r[DET_DOC] && dischg_oc_fet_off_enable);
	assign chg_forced = flag_r[DET_COC] && chg_oc_fet_off_enable;
	assign chg_boosted = flag_r[DET_BOOST] && qual_en[DET_BOOST]
		&& boost_charge_fet_on_enable;

	// Forced off outranks the boost turn-on for the pack's safety
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			CHG_FET_O <= 1'b0;
			DSG_FET_O <= 1'b0;
		end else begin
			CHG_FET_O <= !chg_forced && (charge_fet_on || chg_boosted);
			DSG_FET_O <= !dsg_forced && discharge_fet_on;
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			WAKE_CAL_O <= 1'b0;
			WAKE_INT_O <= 1'b0;
		end else begin
			WAKE_CAL_O <= wake_state_r == WAKE_CAL;
			WAKE_INT_O <= flag_r[DET_WAKE];
		end
	end

	// Read data valid the cycle after the strobe only
	always_comb begin
		rdata_nxt = '0;
		unique case (ADDR_I)
			OFS_FET: rdata_nxt = fet_control_reg;
			OFS_SC1: rdata_nxt = sc1_reg_r;
			OFS_SC2: rdata_nxt = sc2_reg_r;
			OFS_DOC: rdata_nxt = doc_reg_r;
			OFS_COC: rdata_nxt = coc_reg_r;
			OFS_WAKE: rdata_nxt = wake_detect_control;
			OFS_WAKE2: rdata_nxt = wake_detect_control2;
			OFS_STATUS: begin
				rdata_nxt[NUM_FLAGS-1:0] = flag_r;
				rdata_nxt[DSG_FORCED_BIT] = dsg_forced;
				rdata_nxt[CHG_FORCED_BIT] = chg_forced;
				rdata_nxt[CHG_BOOSTED_BIT] = chg_boosted;
			end
			default: rdata_nxt = '0;
		endcase
	end

	always_ff @(posedge CLOCK_I) begin
		if (RST_I || !RD_I) begin
			RDATA_O <= '0;
		end else begin
			RDATA_O <= rdata_nxt;
		end
	end

	dsg_forced_off_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
		dsg_forced |=> !DSG_FET_O)
		else $error("discharge FET on while forced off");

	chg_forced_off_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
		chg_forced && charge_fet_on |=> !CHG_FET_O)
		else $error("charge FET follows software while forced off");

	sw_dsg_control_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
		!dsg_forced && discharge_fet_on |=> DSG_FET_O)
		else $error("discharge FET off without cause");

	boost_force_on_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
		hit[DET_BOOST] && boost_charge_fet_on_enable && !chg_forced
		|=> ##1 CHG_FET_O)
		else $error("boost did not turn charge FET on");

	flag_sticky_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
		flag_r[DET_DOC] && !(status_wr && WDATA_I[DET_DOC]) |=> flag_r[DET_DOC])
		else $error("status flag lost without clear");

	set_beats_clear_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
		hit[DET_SC1] && status_wr && WDATA_I[DET_SC1] |=> flag_r[DET_SC1])
		else $error("event lost against clear");

	fine_range_wins_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
		sc2_reg_r[RANGE_BIT] && sc2_reg_r[2:0] == 3'h0
		|=> !SC2_RANGE_O && SC2_THR_O == SC2_CODE_MAX)
		else $error("overlap level not sent as fine code");

	wake_needs_pd_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
		$rose(flag_r[DET_WAKE]) |-> $past(wake_armed))
		else $error("wake event outside power-down");

	wake_cal_out_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
		wake_state_r == WAKE_IDLE && wake_armed |=> ##1 WAKE_CAL_O)
		else $error("calibration phase not signalled");

	gain_legal_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
		WAKE_GAIN_O != 2'h3)
		else $error("illegal gain code driven");

endmodule

//--- ovc_detect_top_test.sv
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module ovc_detect_top_test
	import ovc_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] rdata;
	logic signed [15:0] sense = 16'sh0000;
	logic [5:0] cmp;
	logic [2:0] sc1_thr, sc2_thr, coc_thr;
	logic [3:0] doc_thr;
	logic sc2_rng, doc_rng, coc_rng, cal, wint, chg, dsg;
	logic [6:0] wake_thr, boost_thr;
	logic [1:0] gain;
	int err_count = 0;
	int checks = 0;
	logic [15:0] d;
	int n;

	initial begin
		forever #4 clk = ~clk;
	end

	// Boost keeps its real qualification time, so its counter is tested at full length
	ovc_detect_top #(.P_SHORT_STEP_TICKS(2), .P_DOC_BASE_TICKS(3), .P_DOC_STEP_TICKS(2),
		.P_WAKE_CAL_TICKS(3), .P_WAKE_PERIOD_TICKS(20)) u_dut (
		.CLOCK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
		.RDATA_O(rdata), .SC1_CMP_I(cmp[DET_SC1]), .SC2_CMP_I(cmp[DET_SC2]),
		.DOC_CMP_I(cmp[DET_DOC]), .COC_CMP_I(cmp[DET_COC]), .BOOST_CMP_I(cmp[DET_BOOST]),
		.WAKE_CMP_I(cmp[DET_WAKE]), .SC1_THR_O(sc1_thr), .SC2_THR_O(sc2_thr),
		.SC2_RANGE_O(sc2_rng), .DOC_THR_O(doc_thr), .DOC_RANGE_O(doc_rng),
		.COC_THR_O(coc_thr), .COC_RANGE_O(coc_rng), .WAKE_THR_O(wake_thr),
		.WAKE_GAIN_O(gain), .BOOST_THR_O(boost_thr), .WAKE_CAL_O(cal), .WAKE_INT_O(wint),
		.CHG_FET_O(chg), .DSG_FET_O(dsg));

	ovc_sense_model u_model (.sense_i(sense), .sc1_thr_i(sc1_thr), .sc2_thr_i(sc2_thr),
		.sc2_range_i(sc2_rng), .doc_thr_i(doc_thr), .doc_range_i(doc_rng),
		.coc_thr_i(coc_thr), .coc_range_i(coc_rng), .wake_thr_i(wake_thr),
		.wake_gain_i(gain), .boost_thr_i(boost_thr), .cmp_o(cmp));

	task automatic tick(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask

	task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask

	task automatic set_sense(input int v);
		@(posedge clk);
		sense <= 16'(v);
	endtask

	// Polls one output per cycle; the bound keeps a dead detector from hanging the run
	task automatic wait_out(input int sel, input logic lvl, output int c);
		c = 0;
		while ((sel == 0 ? chg : sel == 1 ? cal : wint) !== lvl && c < 70000) begin
			tick(1);
			c++;
		end
	endtask

	task automatic wait_flag(input int b, output int c);
		logic [15:0] v;
		c = 0;
		v = 16'h0000;
		while (v[b] !== 1'b1 && c < 2000) begin
			rd_reg(OFS_STATUS, v);
			c++;
		end
	endtask

	// Trip one detector with both FETs on, then release and clear it
	task automatic trip(input logic [3:0] ofs, input logic [15:0] v, input int s,
		input int b, input int lo, input int hi, input bit to_chg);
		int c;
		logic [15:0] st;
		wr_reg(OFS_FET, 16'h0003);
		wr_reg(ofs, v);
		set_sense(s);
		wait_flag(b, c);
		`CHK(c * 2 >= lo && c * 2 <= hi, 1'b1)
		tick(3);
		`CHK(to_chg ? chg : dsg, 1'b0)
		`CHK(to_chg ? dsg : chg, 1'b1)
		wr_reg(OFS_FET, 16'h0003);
		tick(3);
		`CHK(to_chg ? chg : dsg, 1'b0)
		set_sense(0);
		tick(4);
		rd_reg(OFS_STATUS, st);
		`CHK(st[b], 1'b1)
		`CHK(st[to_chg ? CHG_FORCED_BIT : DSG_FORCED_BIT], 1'b1)
		wr_reg(OFS_STATUS, 16'h0001 << b);
		wr_reg(ofs, 16'h0000);
		tick(3);
		rd_reg(OFS_STATUS, st);
		`CHK(st[b], 1'b0)
		`CHK(to_chg ? chg : dsg, 1'b1)
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// About 68k cycles are expected, most of them in the boost wait
	initial begin
		#720000;
		err_count++;
		conclude();
	end

	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		wr_reg(4'h8, 16'hFFFF);
		for (int a = 0; a < 9; a++) begin
			rd_reg(4'(a), d);
			`CHK(d, 16'h0000)
		end
		$display("test reset_values finished");

		wr_reg(OFS_SC1, 16'h0007);
		wr_reg(OFS_SC2, 16'h0010);
		wr_reg(OFS_COC, 16'h0010);
		wr_reg(OFS_DOC, 16'h0010);
		tick(2);
		`CHK(sc1_thr, 3'h7)
		`CHK({sc2_rng, sc2_thr, coc_rng, coc_thr}, 8'h66)
		`CHK({doc_rng, doc_thr}, 5'h0A)
		wr_reg(OFS_SC2, 16'h0013);
		wr_reg(OFS_DOC, 16'h0012);
		tick(2);
		`CHK({sc2_rng, sc2_thr, doc_rng, doc_thr}, 9'h172)
		for (int g = 0; g < 3; g++) begin
			wr_reg(OFS_WAKE, 16'(g << 8) | 16'h0074);
			tick(2);
			`CHK(gain, 2'(g))
		end
		wr_reg(OFS_WAKE2, 16'h0074);
		tick(2);
		`CHK({wake_thr, boost_thr}, 14'h3A74)
		for (int a = 1; a < 7; a++) begin
			wr_reg(4'(a), 16'h0000);
		end
		$display("test thresholds finished");

		wr_reg(OFS_SC2, 16'h9300);
		repeat (2) begin
			set_sense(400);
			tick(384);
			set_sense(0);
			tick(16);
		end
		rd_reg(OFS_STATUS, d);
		`CHK(d[DET_SC2], 1'b0)
		$display("test restart finished");

		trip(OFS_SC1, 16'h9202, 3500, DET_SC1, 376, 656, 1'b0);
		trip(OFS_SC2, 16'h9300, 400, DET_SC2, 632, 912, 1'b0);
		trip(OFS_COC, 16'h9100, -300, DET_COC, 120, 400, 1'b1);
		trip(OFS_DOC, 16'h9012, 700, DET_DOC, 248, 528, 1'b0);
		$display("test detectors finished");

		wr_reg(OFS_FET, 16'h0002);
		wr_reg(OFS_WAKE2, 16'h9064);
		tick(3);
		`CHK(chg, 1'b0)
		set_sense(1200);
		wait_out(0, 1'b1, n);
		`CHK(n >= (BOOST_TICKS - 1) * SLOW_DIV && n <= BOOST_TICKS * SLOW_DIV + 8, 1'b1)
		rd_reg(OFS_STATUS, d);
		`CHK(d[DET_BOOST], 1'b1)
		`CHK(d[CHG_BOOSTED_BIT], 1'b1)
		set_sense(0);
		wr_reg(OFS_WAKE2, 16'h0000);
		wr_reg(OFS_STATUS, 16'h003F);
		$display("test boost finished");

		wr_reg(OFS_WAKE, 16'h8050);
		wr_reg(OFS_FET, 16'h000C);
		tick(40);
		`CHK(cal, 1'b0)
		wr_reg(OFS_FET, 16'h0004);
		wait_out(1, 1'b1, n);
		`CHK(n <= 6, 1'b1)
		wait_out(1, 1'b0, n);
		`CHK(n >= 248 && n <= 400, 1'b1)
		`CHK(wint, 1'b0)
		set_sense(600);
		wait_out(2, 1'b1, n);
		`CHK(n <= 20 * 128, 1'b1)
		rd_reg(OFS_STATUS, d);
		`CHK(d[DET_WAKE], 1'b1)
		set_sense(0);
		wr_reg(OFS_FET, 16'h0000);
		wr_reg(OFS_WAKE, 16'h0000);
		$display("test wake finished");
		conclude();
	end
endmodule

//--- ovc_pkg.sv
package ovc_pkg;

	// Oscillator clock and slow detection clock
	localparam int CLK_PERIOD_NS = 8;
	localparam int SLOW_DIV = 128;
	localparam int DIV_W = 7;
	localparam int SLOW_TICK_NS = CLK_PERIOD_NS * SLOW_DIV;

	// Detection times in their own units
	localparam int SHORT_STEP_NS = 61000;
	localparam int DOC_BASE_NS = 916000;
	localparam int DOC_STEP_NS = 1950000;
	localparam int BOOST_TIME_NS = 488000;
	localparam int WAKE_CAL_NS = 244000;
	localparam int WAKE_PERIOD_NS = 62500000;

	// Least times, rounded up to whole slow ticks
	localparam int SHORT_STEP_TICKS = (SHORT_STEP_NS + SLOW_TICK_NS - 1) / SLOW_TICK_NS;
	localparam int DOC_BASE_TICKS = (DOC_BASE_NS + SLOW_TICK_NS - 1) / SLOW_TICK_NS;
	localparam int DOC_STEP_TICKS = (DOC_STEP_NS + SLOW_TICK_NS - 1) / SLOW_TICK_NS;
	localparam int BOOST_TICKS = (BOOST_TIME_NS + SLOW_TICK_NS - 1) / SLOW_TICK_NS;
	localparam int WAKE_CAL_TICKS = (WAKE_CAL_NS + SLOW_TICK_NS - 1) / SLOW_TICK_NS;
	localparam int WAKE_PERIOD_TICKS = (WAKE_PERIOD_NS + SLOW_TICK_NS - 1) / SLOW_TICK_NS;

	localparam int CNT_W = 16;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 4;

	// Detector and status flag indices
	localparam int DET_SC1 = 0;
	localparam int DET_SC2 = 1;
	localparam int DET_DOC = 2;
	localparam int DET_COC = 3;
	localparam int DET_BOOST = 4;
	localparam int DET_WAKE = 5;
	localparam int NUM_QUAL = 5;
	localparam int NUM_FLAGS = 6;

	// Register offsets
	localparam logic [3:0] OFS_FET = 4'h0;
	localparam logic [3:0] OFS_SC1 = 4'h1;
	localparam logic [3:0] OFS_SC2 = 4'h2;
	localparam logic [3:0] OFS_DOC = 4'h3;
	localparam logic [3:0] OFS_COC = 4'h4;
	localparam logic [3:0] OFS_WAKE = 4'h5;
	localparam logic [3:0] OFS_WAKE2 = 4'h6;
	localparam logic [3:0] OFS_STATUS = 4'h7;

	localparam logic [15:0] RST_REG = 16'h0000;

	// Field positions
	localparam int CHG_ON_BIT = 0;
	localparam int DSG_ON_BIT = 1;
	localparam int PWRDN_BIT = 2;
	localparam int INTEG_EN_BIT = 3;
	localparam int RANGE_BIT = 4;
	localparam int TIME_LSB = 8;
	localparam int GAIN_LSB = 8;
	localparam int FET_EN_BIT = 12;
	localparam int DET_EN_BIT = 15;
	localparam int DSG_FORCED_BIT = 8;
	localparam int CHG_FORCED_BIT = 9;
	localparam int CHG_BOOSTED_BIT = 10;

	// Code limits
	localparam logic [3:0] SHORT_TIME_MAX = 4'hF;
	localparam logic [2:0] SC2_CODE_MAX = 3'h6;
	localparam logic [3:0] DOC_CODE_MAX = 4'hA;
	localparam logic [6:0] WAKE_CODE_MAX = 7'h74;

	localparam logic [1:0] GAIN_X10 = 2'h0;
	localparam logic [1:0] GAIN_X5 = 2'h1;
	localparam logic [1:0] GAIN_X2 = 2'h2;

	typedef enum logic [1:0] {WAKE_IDLE, WAKE_CAL, WAKE_MEAS} ovc_wake_e;

endpackage

//--- ovc_prescale.sv
`timescale 1ns/10ps
module ovc_prescale
	import ovc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	output logic tick_o
);

	logic [DIV_W-1:0] div_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_r <= '0;
		end else begin
			div_r <= div_r + 1'b1;
		end
	end

	assign tick_o = &div_r;

	slow_tick_period_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tick_o |=> !tick_o ##127 tick_o)
		else $error("slow tick not one in 128 cycles");

endmodule

//--- ovc_qualify.sv
`timescale 1ns/10ps
module ovc_qualify
	import ovc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic enable_i,
	input wire logic cmp_i,
	input wire logic tick_i,
	input wire logic [CNT_W-1:0] limit_i,
	output logic hit_o
);

	logic [CNT_W-1:0] cnt_r;
	logic done_r;

	// Any drop of the comparator restarts the time
	always_ff @(posedge clk_i) begin
		if (rst_i || !enable_i || !cmp_i) begin
			cnt_r <= '0;
		end else if (tick_i && cnt_r < limit_i) begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	// One event per continuous assertion
	always_ff @(posedge clk_i) begin
		if (rst_i || !enable_i || !cmp_i) begin
			done_r <= 1'b0;
		end else if (cnt_r >= limit_i) begin
			done_r <= 1'b1;
		end
	end

	assign hit_o = enable_i && cmp_i && cnt_r >= limit_i && !done_r;

	qualify_restart_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!cmp_i |=> cnt_r == '0 && (!hit_o || limit_i == '0))
		else $error("detector timer not restarted");

endmodule

//--- ovc_sense_model.sv
`timescale 1ns/10ps
module ovc_sense_model
	import ovc_pkg::*;
(
	input wire logic signed [15:0] sense_i,
	input wire logic [2:0] sc1_thr_i,
	input wire logic [2:0] sc2_thr_i,
	input wire logic sc2_range_i,
	input wire logic [3:0] doc_thr_i,
	input wire logic doc_range_i,
	input wire logic [2:0] coc_thr_i,
	input wire logic coc_range_i,
	input wire logic [6:0] wake_thr_i,
	input wire logic [1:0] wake_gain_i,
	input wire logic [6:0] boost_thr_i,
	output logic [5:0] cmp_o
);
	// Levels in 0.1 mV units; ideal comparators, no offset, so edges are exact
	function automatic int lvl2(input int code, input logic coarse);
		return coarse ? 1000 + 250 * code : 250 + 125 * code;
	endfunction

	always_comb begin
		int s;
		int g;
		s = int'(sense_i);
		g = (wake_gain_i == GAIN_X5) ? 5 : (wake_gain_i == GAIN_X2) ? 2 : 10;
		cmp_o[DET_SC1] = s >= 1000 * (int'(sc1_thr_i) + 1);
		cmp_o[DET_SC2] = s >= lvl2(int'(sc2_thr_i), sc2_range_i);
		cmp_o[DET_DOC] = s >= (doc_range_i ? 500 + 50 * int'(doc_thr_i)
			: 250 + 25 * int'(doc_thr_i));
		cmp_o[DET_COC] = s <= -lvl2(int'(coc_thr_i), coc_range_i);
		cmp_o[DET_BOOST] = s >= -1450 + 25 * int'(boost_thr_i);
		cmp_o[DET_WAKE] = s * g / 10 >= -1450 + 25 * int'(wake_thr_i);
	end
endmodule
